// File: pkg/display_ctrl_defines.svh
// port addresses, index values, field positions and reset values
`ifndef DISPLAY_CTRL_DEFINES_SVH
`define DISPLAY_CTRL_DEFINES_SVH

`define PORT_MONO_CRT_INDEX 10'h3B4
`define PORT_MONO_CRT_DATA 10'h3B5
`define PORT_COLOR_CRT_INDEX 10'h3D4
`define PORT_COLOR_CRT_DATA 10'h3D5
`define PORT_MONO_MODE_CONTROL 10'h3B8
`define PORT_MONO_CRT_STATUS 10'h3BA
`define PORT_MONO_GRAPHICS_CONFIG 10'h3BF
`define PORT_ATTR_WRITE 10'h3C0
`define PORT_ATTR_READ 10'h3C1
`define PORT_PALETTE_PIXEL_MASK 10'h3C6
`define PORT_PALETTE_READ_INDEX 10'h3C7
`define PORT_PALETTE_WRITE_INDEX 10'h3C8
`define PORT_PALETTE_DATA 10'h3C9
`define PORT_COLOR_MODE_CONTROL 10'h3D8
`define PORT_COLOR_COLOR_SELECT 10'h3D9
`define PORT_COLOR_CRT_STATUS 10'h3DA

`define IDX_EXT_PORT 8'hFC
`define IDX_EXT_CONTROL_ONE 8'hFD
`define IDX_EXT_CONTROL_TWO 8'hFE
`define IDX_SKEW 4'h8
`define IDX_CURSOR_START 4'hA
`define IDX_START_HIGH 4'hC
`define IDX_START_LOW 4'hD
`define IDX_CURSOR_HIGH 4'hE
`define IDX_CURSOR_LOW 4'hF
`define IDX_ATTR_LAST 5'h14
`define IDX_ATTR_MODE 5'h10
`define CRT_LEGACY_LAST 4'hF
`define ATTR_IDX_MSB 4
`define CRT_LEGACY_IDX_MSB 3

`define CURSOR_BLINK_MASK 8'h9F
`define CURSOR_KEEP_ALL 8'hFF
`define PALETTE_STATUS_READ_MODE 8'h03
`define PALETTE_STATUS_WRITE_MODE 8'h00
`define PALETTE_ADDR_PIXEL_MASK 2'h0
`define PALETTE_ADDR_READ_INDEX 2'h1
`define PALETTE_ADDR_WRITE_INDEX 2'h2
`define PALETTE_ADDR_DATA 2'h3
`define REG_RESET 8'h00
`define UNMAPPED_READ 8'hFF

`endif

// File: pkg/display_ctrl_pkg.sv
// types shared by the port decode bank
package display_ctrl_pkg;

  typedef enum logic [1:0]
  {
    mode_native,
    mode_mono_text,
    mode_mono_graphics,
    mode_color_legacy
  } display_mode_t;

  typedef enum logic [1:0]
  {
    rd_idle,
    rd_answer,
    rd_palette_wait
  } read_state_t;

endpackage

// File: design/display_ctrl_port_decode_bank.sv
// i/o port register bank and decoder for the display controller
`timescale 1ns/100ps
`include "display_ctrl_defines.svh"
// Behaviour
// [RL1] attribute index and data share one write port
// [RL2] extended registers reached via crt index FC-FE
// [RL3] native crt ports at 3B4/5 or 3D4/5
// [RL4] palette ports 3C6-3C9 drive external strobes
// [RL5] 3C7 reads local status, writes go external
// [RL6] legacy modes reach extended registers identically
// [RL7] legacy crt ports follow mono or color mode
// [RL8] start and cursor addresses are 16 bits
// [RL9] scanning is always non-interlaced in legacy modes
// [RL10] no cursor blinking in legacy modes
// [RL11] port 3BF decoded only in mono graphics mode
// [RL12] mono mode control and status at 3B8/3BA
// [RL13] color legacy registers at 3D8, 3D9, 3DA
// [RL14] extended registers behave alike in every mode
// [RL15] index registers hold across data accesses
module display_ctrl_port_decode_bank
(
  // clock and reset
  input wire logic clock,
  input wire logic srst,
  // host i/o bus, one-cycle strobes on this clock
  input wire logic [9:0] io_addr,
  input wire logic io_rd,
  input wire logic io_wr,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata,
  output logic io_rd_valid,
  // mode selection from the surrounding controller
  input wire logic [1:0] display_mode,
  input wire logic color_addressing,
  // status sources from the display timing
  input wire logic [7:0] mono_status_in,
  input wire logic [7:0] color_status_in,
  // external palette converter
  output logic palette_read_strobe,
  output logic palette_write_strobe,
  output logic [1:0] palette_addr,
  output logic [7:0] palette_wdata,
  input wire logic [7:0] palette_rdata,
  // register contents toward the display logic
  output logic [7:0] extended_control_one,
  output logic [7:0] extended_control_two,
  output logic [7:0] general_port_register,
  output logic [15:0] start_address,
  output logic [15:0] cursor_address,
  output logic [7:0] cursor_start_raster,
  output logic interlace_enable,
  output logic [7:0] mono_mode_control,
  output logic [7:0] mono_graphics_configuration,
  output logic [7:0] color_legacy_mode_control,
  output logic [7:0] color_legacy_color_select,
  output logic [7:0] attr_mode_control
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [7:0] crt_index;
  logic [7:0] attribute_index;
  logic attr_data_phase;
  logic [7:0] crt_regs [0:`CRT_LEGACY_LAST];
  logic [7:0] attr_regs [0:`IDX_ATTR_LAST];
  logic [7:0] palette_status;
  display_ctrl_pkg::read_state_t rd_state;
  logic [7:0] next_rdata;
  logic [7:0] held_rdata;

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  function automatic logic is_mono_mode(input logic [1:0] m);
    is_mono_mode = (m == display_ctrl_pkg::mode_mono_text) ||
      (m == display_ctrl_pkg::mode_mono_graphics);
  endfunction

  // middle digit B for mono, D for color, native or legacy
  logic crt_mono;
  always_comb
  begin
    if (display_mode == display_ctrl_pkg::mode_native)
      crt_mono = !color_addressing; // [RL3]
    else
      crt_mono = is_mono_mode(display_mode); // [RL7]
  end

  logic hit_crt_index;
  logic hit_crt_data;
  assign hit_crt_index = crt_mono ? (io_addr == `PORT_MONO_CRT_INDEX)
    : (io_addr == `PORT_COLOR_CRT_INDEX); // [RL3] [RL7]
  assign hit_crt_data = crt_mono ? (io_addr == `PORT_MONO_CRT_DATA)
    : (io_addr == `PORT_COLOR_CRT_DATA); // [RL3] [RL7]

  logic legacy;
  assign legacy = display_mode != display_ctrl_pkg::mode_native;

  logic hit_mono_mode;
  logic hit_mono_status;
  logic hit_mono_config;
  logic hit_color_mode;
  logic hit_color_select;
  logic hit_color_status;
  assign hit_mono_mode = is_mono_mode(display_mode) &&
    (io_addr == `PORT_MONO_MODE_CONTROL); // [RL12]
  assign hit_mono_status = is_mono_mode(display_mode) &&
    (io_addr == `PORT_MONO_CRT_STATUS); // [RL12]
  assign hit_mono_config =
    (display_mode == display_ctrl_pkg::mode_mono_graphics) &&
    (io_addr == `PORT_MONO_GRAPHICS_CONFIG); // [RL11]
  assign hit_color_mode =
    (display_mode == display_ctrl_pkg::mode_color_legacy) &&
    (io_addr == `PORT_COLOR_MODE_CONTROL); // [RL13]
  assign hit_color_select =
    (display_mode == display_ctrl_pkg::mode_color_legacy) &&
    (io_addr == `PORT_COLOR_COLOR_SELECT); // [RL13]
  assign hit_color_status =
    (display_mode == display_ctrl_pkg::mode_color_legacy) &&
    (io_addr == `PORT_COLOR_CRT_STATUS); // [RL13]

  // palette converter owns 3C6, 3C8, 3C9 and the write side of 3C7
  logic hit_palette;
  logic [1:0] palette_sel;
  always_comb
  begin
    hit_palette = 1'b1;
    palette_sel = `PALETTE_ADDR_PIXEL_MASK;
    case (io_addr)
      `PORT_PALETTE_PIXEL_MASK: palette_sel = `PALETTE_ADDR_PIXEL_MASK;
      `PORT_PALETTE_READ_INDEX: palette_sel = `PALETTE_ADDR_READ_INDEX;
      `PORT_PALETTE_WRITE_INDEX: palette_sel = `PALETTE_ADDR_WRITE_INDEX;
      `PORT_PALETTE_DATA: palette_sel = `PALETTE_ADDR_DATA;
      default: hit_palette = 1'b0;
    endcase
  end

  logic palette_ext_rd;
  logic palette_ext_wr;
  assign palette_ext_rd = io_rd && hit_palette &&
    (io_addr != `PORT_PALETTE_READ_INDEX); // [RL4] [RL5]
  assign palette_ext_wr = io_wr && hit_palette; // [RL4] [RL5]

  // crt data target, legacy table holds indices 00-0F
  logic crt_legacy_idx;
  assign crt_legacy_idx = crt_index[7:`CRT_LEGACY_IDX_MSB+1] == '0;
  logic attr_idx_ok;
  assign attr_idx_ok = attribute_index[`ATTR_IDX_MSB:0] <= `IDX_ATTR_LAST
    && attribute_index[7:`ATTR_IDX_MSB+1] == '0;

  // ---------------------------------------------------------------
  // index registers
  // ---------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (srst)
      crt_index <= `REG_RESET;
    else if (io_wr && hit_crt_index)
      crt_index <= io_wdata; // [RL15] [RL2] [RL6]
  end

  // writes to 3C0 alternate between index and data
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      attribute_index <= `REG_RESET;
      attr_data_phase <= 1'b0;
    end
    else if (io_wr && io_addr == `PORT_ATTR_WRITE)
    begin
      attr_data_phase <= !attr_data_phase; // [RL1]
      if (!attr_data_phase)
        attribute_index <= io_wdata; // [RL1] [RL15]
    end
  end

  // ---------------------------------------------------------------
  // attribute section
  // ---------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      for (int i = 0; i <= `IDX_ATTR_LAST; i++)
        attr_regs[i] <= `REG_RESET;
    end
    else if (io_wr && io_addr == `PORT_ATTR_WRITE && attr_data_phase
      && attr_idx_ok)
      attr_regs[attribute_index[`ATTR_IDX_MSB:0]] <= io_wdata; // [RL1]
  end

  // ---------------------------------------------------------------
  // crt legacy table and extended registers
  // ---------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      for (int i = 0; i <= `CRT_LEGACY_LAST; i++)
        crt_regs[i] <= `REG_RESET;
    end
    else if (io_wr && hit_crt_data && crt_legacy_idx)
      crt_regs[crt_index[`CRT_LEGACY_IDX_MSB:0]] <= io_wdata; // [RL15]
  end

  // same decode in native and legacy modes
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      extended_control_one <= `REG_RESET;
      extended_control_two <= `REG_RESET;
      general_port_register <= `REG_RESET;
    end
    else if (io_wr && hit_crt_data)
    begin
      case (crt_index)
        `IDX_EXT_CONTROL_ONE: extended_control_one <= io_wdata; // [RL2] [RL14]
        `IDX_EXT_CONTROL_TWO: extended_control_two <= io_wdata; // [RL2] [RL14]
        `IDX_EXT_PORT: general_port_register <= io_wdata; // [RL2] [RL14]
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // legacy port registers
  // ---------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      mono_mode_control <= `REG_RESET;
      mono_graphics_configuration <= `REG_RESET;
      color_legacy_mode_control <= `REG_RESET;
      color_legacy_color_select <= `REG_RESET;
    end
    else if (io_wr)
    begin
      if (hit_mono_mode)
        mono_mode_control <= io_wdata; // [RL12]
      if (hit_mono_config)
        mono_graphics_configuration <= io_wdata; // [RL11]
      if (hit_color_mode)
        color_legacy_mode_control <= io_wdata; // [RL13]
      if (hit_color_select)
        color_legacy_color_select <= io_wdata; // [RL13]
    end
  end

  // ---------------------------------------------------------------
  // palette status and converter strobes
  // ---------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (srst)
      palette_status <= `PALETTE_STATUS_WRITE_MODE;
    else if (io_wr && io_addr == `PORT_PALETTE_READ_INDEX)
      palette_status <= `PALETTE_STATUS_READ_MODE; // [RL5]
    else if (io_wr && io_addr == `PORT_PALETTE_WRITE_INDEX)
      palette_status <= `PALETTE_STATUS_WRITE_MODE;
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      palette_read_strobe <= 1'b0;
      palette_write_strobe <= 1'b0;
      palette_addr <= `PALETTE_ADDR_PIXEL_MASK;
      palette_wdata <= `REG_RESET;
    end
    else
    begin
      palette_read_strobe <= palette_ext_rd; // [RL4]
      palette_write_strobe <= palette_ext_wr; // [RL4] [RL5]
      if (palette_ext_rd || palette_ext_wr)
        palette_addr <= palette_sel;
      if (palette_ext_wr)
        palette_wdata <= io_wdata;
    end
  end

  // ---------------------------------------------------------------
  // display-facing views
  // ---------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      start_address <= '0;
      cursor_address <= '0;
      cursor_start_raster <= `REG_RESET;
      interlace_enable <= 1'b0;
      attr_mode_control <= `REG_RESET;
    end
    else
    begin
      start_address <= {crt_regs[`IDX_START_HIGH],
        crt_regs[`IDX_START_LOW]}; // [RL8]
      cursor_address <= {crt_regs[`IDX_CURSOR_HIGH],
        crt_regs[`IDX_CURSOR_LOW]}; // [RL8]
      // in legacy modes blink control bits are dropped before the cursor logic
      cursor_start_raster <= crt_regs[`IDX_CURSOR_START] &
        (legacy ? `CURSOR_BLINK_MASK : `CURSOR_KEEP_ALL); // [RL10]
      // the skew register is stored but never turns on interlace
      interlace_enable <= 1'b0; // [RL9]
      attr_mode_control <= attr_regs[`IDX_ATTR_MODE];
    end
  end

  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------
  always_comb
  begin
    next_rdata = `UNMAPPED_READ;
    if (hit_crt_index)
      next_rdata = crt_index;
    else if (hit_crt_data)
    begin
      if (crt_legacy_idx)
        next_rdata = crt_regs[crt_index[`CRT_LEGACY_IDX_MSB:0]];
      else if (crt_index == `IDX_EXT_CONTROL_ONE)
        next_rdata = extended_control_one; // [RL2]
      else if (crt_index == `IDX_EXT_CONTROL_TWO)
        next_rdata = extended_control_two; // [RL2]
      else if (crt_index == `IDX_EXT_PORT)
        next_rdata = general_port_register; // [RL2]
    end
    else if (io_addr == `PORT_ATTR_WRITE)
      next_rdata = attribute_index;
    else if (io_addr == `PORT_ATTR_READ)
      next_rdata = attr_idx_ok ?
        attr_regs[attribute_index[`ATTR_IDX_MSB:0]] : `REG_RESET; // [RL1]
    else if (io_addr == `PORT_PALETTE_READ_INDEX)
      next_rdata = palette_status; // [RL5]
    else if (hit_mono_mode)
      next_rdata = mono_mode_control;
    else if (hit_mono_status)
      next_rdata = mono_status_in; // [RL12]
    else if (hit_mono_config)
      next_rdata = mono_graphics_configuration; // [RL11]
    else if (hit_color_mode)
      next_rdata = color_legacy_mode_control;
    else if (hit_color_select)
      next_rdata = color_legacy_color_select;
    else if (hit_color_status)
      next_rdata = color_status_in; // [RL13]
  end

  // external reads take the converter's data in the wait state, with the same latency as local reads
  always_ff @(posedge clock)
  begin
    if (srst)
      rd_state <= display_ctrl_pkg::rd_idle;
    else if (palette_ext_rd)
      rd_state <= display_ctrl_pkg::rd_palette_wait;
    else if (io_rd)
      rd_state <= display_ctrl_pkg::rd_answer;
    else
      rd_state <= display_ctrl_pkg::rd_idle;
  end

  always_ff @(posedge clock)
  begin
    if (srst)
      held_rdata <= `REG_RESET;
    else if (io_rd)
      held_rdata <= next_rdata;
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      io_rdata <= `REG_RESET;
      io_rd_valid <= 1'b0;
    end
    else
    begin
      case (rd_state)
        display_ctrl_pkg::rd_answer:
        begin
          io_rdata <= held_rdata;
          io_rd_valid <= 1'b1;
        end
        display_ctrl_pkg::rd_palette_wait:
        begin
          io_rdata <= palette_rdata; // [RL4]
          io_rd_valid <= 1'b1;
        end
        default:
          io_rd_valid <= 1'b0;
      endcase
    end
  end

endmodule // display_ctrl_port_decode_bank

// File: tb/display_ctrl_port_decode_bank_sva.sv
// checker for the port decode bank
`timescale 1ns/100ps
module display_ctrl_port_decode_bank_sva
(
  // clock and reset
  input wire logic clock,
  input wire logic srst,
  // host bus
  input wire logic [9:0] io_addr,
  input wire logic io_rd,
  input wire logic io_wr,
  input wire logic [7:0] io_wdata,
  input wire logic [7:0] io_rdata,
  input wire logic io_rd_valid,
  // modes and status
  input wire logic [1:0] display_mode,
  input wire logic [7:0] mono_status_in,
  // palette converter
  input wire logic palette_read_strobe,
  input wire logic palette_write_strobe,
  input wire logic [1:0] palette_addr,
  input wire logic [7:0] palette_wdata,
  input wire logic [7:0] palette_rdata,
  // register views
  input wire logic [7:0] cursor_start_raster,
  input wire logic interlace_enable,
  input wire logic [7:0] mono_graphics_configuration,
  input wire logic [7:0] color_legacy_color_select
);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);
  wire logic [1:0] pal_code = io_addr[1:0] + 2'h2;
  wire logic pal_port = io_addr inside {[10'h3C6:10'h3C9]};
  sequence pal_rd_req;
    io_rd && pal_port && io_addr != 10'h3C7;
  endsequence
  sequence pal_rd_done;
    ##1 palette_read_strobe ##1 io_rd_valid;
  endsequence
  a_pal_wr_strobe: assert property (io_wr && pal_port |=>
    palette_write_strobe && palette_addr == $past(pal_code) &&
    palette_wdata == $past(io_wdata)) else $error("palette write bad");
  a_pal_rd_strobe: assert property (pal_rd_req |-> pal_rd_done)
    else $error("palette read strobe missing");
  a_pal_rd_data: assert property (palette_read_strobe |=>
    io_rd_valid && io_rdata == $past(palette_rdata))
    else $error("palette read data lost");
  a_status_stays_local: assert property (io_rd && io_addr == 10'h3C7
    |=> !palette_read_strobe) else $error("status read went out");
  a_read_answer_time: assert property (io_rd |-> ##2 io_rd_valid)
    else $error("read answer late");
  a_no_interlace: assert property (interlace_enable == 1'b0)
    else $error("interlace seen");
  a_no_cursor_blink: assert property (display_mode != 2'h0 &&
    $past(display_mode) != 2'h0 |-> cursor_start_raster[6:5] == 2'b00)
    else $error("blink bits set");
  a_mono_status_read: assert property (io_rd && io_addr == 10'h3BA &&
    display_mode inside {2'h1, 2'h2} |-> ##2 io_rdata == mono_status_in)
    else $error("mono status wrong");
  a_config_ignored: assert property (io_wr && io_addr == 10'h3BF &&
    display_mode != 2'h2 |=> $stable(mono_graphics_configuration))
    else $error("config written outside mode");
  a_config_taken: assert property (io_wr && io_addr == 10'h3BF &&
    display_mode == 2'h2 |=> mono_graphics_configuration == $past(io_wdata))
    else $error("config not written");
  a_color_select_wr: assert property (io_wr && io_addr == 10'h3D9 &&
    display_mode == 2'h3 |=> color_legacy_color_select == $past(io_wdata))
    else $error("color select not written");
endmodule // display_ctrl_port_decode_bank_sva

bind display_ctrl_port_decode_bank display_ctrl_port_decode_bank_sva u_sva
(
  .clock(clock), .srst(srst), .io_addr(io_addr), .io_rd(io_rd),
  .io_wr(io_wr), .io_wdata(io_wdata), .io_rdata(io_rdata),
  .io_rd_valid(io_rd_valid), .display_mode(display_mode),
  .mono_status_in(mono_status_in),
  .palette_read_strobe(palette_read_strobe),
  .palette_write_strobe(palette_write_strobe),
  .palette_addr(palette_addr), .palette_wdata(palette_wdata),
  .palette_rdata(palette_rdata),
  .cursor_start_raster(cursor_start_raster),
  .interlace_enable(interlace_enable),
  .mono_graphics_configuration(mono_graphics_configuration),
  .color_legacy_color_select(color_legacy_color_select)
);

// File: tb/palette_converter_model.sv
// behavioural model of the external palette converter
`timescale 1ns/100ps
module palette_converter_model
(
  // clock
  input wire logic clock,
  // strobes and data from the device
  input wire logic palette_read_strobe,
  input wire logic palette_write_strobe,
  input wire logic [1:0] palette_addr,
  input wire logic [7:0] palette_wdata,
  output logic [7:0] palette_rdata
);
  // ----------------------------------------
  // storage and read bus
  // ----------------------------------------
  logic [7:0] store [4] = '{default: 8'h00};
  logic [7:0] last = 8'h00;
  always @(posedge clock)
  begin
    if (palette_write_strobe)
      store[palette_addr] <= palette_wdata;
    if (palette_read_strobe)
      last <= store[palette_addr];
  end
  // released bus shows the inverse of the last value
  assign palette_rdata = palette_read_strobe ? store[palette_addr]
    : ~last;
endmodule // palette_converter_model

// File: tb/tb_display_ctrl_port_decode_bank.sv
// self-checking bench for the port decode bank
`timescale 1ns/100ps
module tb_display_ctrl_port_decode_bank;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic [9:0] io_addr = 10'h000;
  logic io_rd = 1'b0;
  logic io_wr = 1'b0;
  logic [7:0] io_wdata = 8'h00;
  logic [1:0] display_mode = 2'h0;
  logic color_addressing = 1'b1;
  logic [7:0] mono_status_in = 8'h5C;
  logic [7:0] color_status_in = 8'hA3;
  logic [7:0] io_rdata, palette_wdata, palette_rdata, cursor_start_raster;
  logic io_rd_valid, palette_read_strobe, palette_write_strobe;
  logic interlace_enable;
  logic [1:0] palette_addr;
  logic [7:0] ext_one, ext_two, port_reg, mono_mode, mono_cfg;
  logic [7:0] color_mode, color_sel, attr_mode;
  logic [15:0] start_address, cursor_address;
  logic [7:0] m;
  logic [9:0] b;
  int num_errors = 0;
  int checks_done = 0;
  int cycles = 0;

  always #12.5 clock = ~clock;

  display_ctrl_port_decode_bank DUT
  (
    .clock(clock), .srst(srst), .io_addr(io_addr), .io_rd(io_rd),
    .io_wr(io_wr), .io_wdata(io_wdata), .io_rdata(io_rdata),
    .io_rd_valid(io_rd_valid), .display_mode(display_mode),
    .color_addressing(color_addressing), .mono_status_in(mono_status_in),
    .color_status_in(color_status_in),
    .palette_read_strobe(palette_read_strobe),
    .palette_write_strobe(palette_write_strobe),
    .palette_addr(palette_addr), .palette_wdata(palette_wdata),
    .palette_rdata(palette_rdata), .extended_control_one(ext_one),
    .extended_control_two(ext_two), .general_port_register(port_reg),
    .start_address(start_address), .cursor_address(cursor_address),
    .cursor_start_raster(cursor_start_raster),
    .interlace_enable(interlace_enable), .mono_mode_control(mono_mode),
    .mono_graphics_configuration(mono_cfg),
    .color_legacy_mode_control(color_mode),
    .color_legacy_color_select(color_sel), .attr_mode_control(attr_mode)
  );

  palette_converter_model u_palette
  (
    .clock(clock), .palette_read_strobe(palette_read_strobe),
    .palette_write_strobe(palette_write_strobe),
    .palette_addr(palette_addr), .palette_wdata(palette_wdata),
    .palette_rdata(palette_rdata)
  );

  // ----------------------------------------
  // bus tasks and checks
  // ----------------------------------------
  task end_of_test();
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge clock);
    io_addr <= a;
    io_wdata <= d;
    io_wr <= 1'b1;
    @(posedge clock);
    io_wr <= 1'b0;
  endtask

  task rc(input logic [9:0] a, input logic [7:0] exp);
    logic [7:0] d;
    d = 8'hxx;
    @(posedge clock);
    io_addr <= a;
    io_rd <= 1'b1;
    @(posedge clock);
    io_rd <= 1'b0;
    repeat (3)
    begin
      @(negedge clock);
      if (io_rd_valid === 1'b1) d = io_rdata;
    end
    chk(d, exp);
  endtask

  task settle();
    repeat (2) @(negedge clock);
  endtask

  task set_mode(input logic [1:0] md);
    @(posedge clock);
    display_mode <= md;
  endtask

  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      num_errors++;
      end_of_test();
    end
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    repeat (8) @(posedge clock);
    srst <= 1'b0;
    settle();
    chk(ext_one, 16'h0000);
    chk(port_reg, 16'h0000);
    // extended registers in every mode, index held over data writes
    for (m = 8'h00; m < 8'h04; m++)
    begin
      set_mode(m[1:0]);
      b = (m == 8'h01 || m == 8'h02) ? 10'h3B4 : 10'h3D4;
      wr(b, 8'hFD);
      wr(b + 10'h001, 8'h10 + m);
      wr(b + 10'h001, 8'h20 + m);
      wr(b, 8'hFE);
      wr(b + 10'h001, 8'h30 + m);
      wr(b, 8'hFC);
      wr(b + 10'h001, 8'h40 + m);
      rc(b + 10'h001, 8'h40 + m);
      wr(b, 8'hFD);
      rc(b + 10'h001, 8'h20 + m);
      rc((b ^ 10'h060) + 10'h001, 8'hFF);
      settle();
      chk(ext_two, 8'h30 + m);
    end
    set_mode(2'h0);
    color_addressing <= 1'b0;
    wr(10'h3B4, 8'hFD);
    rc(10'h3B5, 8'h23);
    rc(10'h3D5, 8'hFF);
    // legacy 16-bit addresses, skew and cursor start
    set_mode(2'h1);
    for (m = 8'h00; m < 8'h04; m++)
    begin
      wr(10'h3B4, 8'h0C + m);
      wr(10'h3B5, 8'h12 + 8'h22 * m);
    end
    wr(10'h3B4, 8'h08);
    wr(10'h3B5, 8'hFF);
    wr(10'h3B4, 8'h0A);
    wr(10'h3B5, 8'hFF);
    settle();
    chk(start_address, 16'h1234);
    chk(cursor_address, 16'h5678);
    chk(interlace_enable, 16'h0000);
    chk(cursor_start_raster, 16'h009F);
    // mode registers per legacy mode
    wr(10'h3B8, 8'h29);
    rc(10'h3B8, 8'h29);
    rc(10'h3BA, 8'h5C);
    wr(10'h3BF, 8'h03);
    rc(10'h3BF, 8'hFF);
    rc(10'h3D8, 8'hFF);
    set_mode(2'h2);
    wr(10'h3BF, 8'h03);
    rc(10'h3BF, 8'h03);
    rc(10'h3BA, 8'h5C);
    set_mode(2'h3);
    wr(10'h3BF, 8'h05);
    wr(10'h3D8, 8'h1A);
    wr(10'h3D9, 8'h2B);
    rc(10'h3D8, 8'h1A);
    rc(10'h3D9, 8'h2B);
    rc(10'h3DA, 8'hA3);
    rc(10'h3BA, 8'hFF);
    chk(mono_cfg, 16'h0003);
    chk(mono_mode, 16'h0029);
    chk(color_mode, 16'h001A);
    chk(port_reg, 16'h0043);
    // attribute index and data phases
    set_mode(2'h0);
    wr(10'h3C0, 8'h11);
    wr(10'h3C0, 8'h5A);
    wr(10'h3C0, 8'h10);
    wr(10'h3C0, 8'h3C);
    rc(10'h3C1, 8'h3C);
    rc(10'h3C1, 8'h3C);
    wr(10'h3C0, 8'h15);
    wr(10'h3C0, 8'h77);
    rc(10'h3C1, 8'h00);
    wr(10'h3C0, 8'h11);
    rc(10'h3C1, 8'h5A);
    wr(10'h3C0, 8'h5B);
    wr(10'h3C0, 8'h0F);
    wr(10'h3C0, 8'hA5);
    rc(10'h3C1, 8'hA5);
    chk(attr_mode, 16'h003C);
    // palette converter ports and local status
    wr(10'h3C8, 8'h07);
    wr(10'h3C9, 8'hC4);
    rc(10'h3C9, 8'hC4);
    rc(10'h3C8, 8'h07);
    rc(10'h3C7, 8'h00);
    wr(10'h3C7, 8'h01);
    rc(10'h3C7, 8'h03);
    wr(10'h3C6, 8'hF0);
    rc(10'h3C6, 8'hF0);
    end_of_test();
  end
endmodule // tb_display_ctrl_port_decode_bank
